//--- logic/vxu_card_if.sv
// Card user interface: APB host side, expansion bus, static IO,
// interrupter, trigger routing, clock, clear and indicator drives.
// Assumes APB from the host and asynchronous pins from the user board.
//
// Behaviour
// R1: Buffered 16-bit expansion bus, four address lines, strobe, write line.
// R2: Only word registers 20h to 38h go to the expansion bus.
// R3: Expansion strobe goes low while an expansion register is addressed.
// R4: Write line low on expansion writes, high on reads.
// R5: Hold input low before strobe end stalls the host until released.
// R6: User presents three cause bits, first input least significant.
// R7: Interrupt request pulse raises chosen IRQ line and latches cause.
// R8: Reset jumper turns third cause input into active-low board reset.
// R9: Active-low clear pulse output resets the user board.
// R10: 48 static lines as three 16-bit banks, direction per bank.
// R11: Output strobe pulses once newly written output data is stable.
// R12: Data-ready input sets a flip-flop that drives the inhibit output.
// R13: User keeps static inputs steady while inhibit is asserted.
// R14: Selected even trigger line routed to user trigger input.
// R15: Adjacent odd trigger line driven from user trigger output.
// R16: 10 MHz user clock from backplane or local source by jumper.
// R17: Access indicator on while a mapped address is selected.
// R18: Ready indicator after self test done, fail indicator on failure.
// R19: Backplane failure indicator follows the system failure line.
// R20: User holds cause bits stable around the interrupt request pulse.
`default_nettype none

module vxu_card_if
	import vxu_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] exp_data_in,
	output logic      [15:0] exp_data_out,
	output logic             exp_data_oe,
	output logic      [3:0]  exp_addr,
	output logic             exp_transfer_strobe_n,
	output logic             exp_write_n,
	input  wire logic        transfer_hold_n,
	input  wire logic [47:0] static_io_lines_in,
	output logic      [47:0] static_io_lines_out,
	output logic      [47:0] static_io_lines_oe,
	output logic             output_data_strobe_n,
	input  wire logic        external_data_ready_n,
	output logic             input_inhibit_n,
	input  wire logic        user_irq_req_n,
	input  wire logic        int_code_bit0,
	input  wire logic        int_code_bit1,
	input  wire logic        int_code_bit2_or_board_reset_n,
	input  wire logic        reset_jumper_fitted,
	output logic      [6:0]  vxi_irq_out,
	output logic      [6:0]  vxi_irq_oe,
	input  wire logic [7:0]  vxi_ttltrg_in,
	output logic      [7:0]  vxi_ttltrg_out,
	output logic      [7:0]  vxi_ttltrg_oe,
	output logic             user_trigger_in_n,
	input  wire logic        user_trigger_out_n,
	input  wire logic        backplane_clk10,
	input  wire logic        clk_source_backplane,
	output logic             user_clk10,
	output logic             user_clear_n,
	output logic             access_indicator_n,
	output logic             ready_indicator_n,
	output logic             selftest_failed_indicator_n,
	input  wire logic        vxi_sysfail_n,
	output logic             backplane_failure_indicator_n
);

	localparam int SYNC_W = 83;

	typedef struct packed {
		vxu_state_t        state;
		logic [3:0]        cnt;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic [CTRL_W-1:0] ctrl;
		logic [47:0]       io_out;
		logic [3:0]        exp_addr;
		logic              exp_stb_n;
		logic              exp_wr_n;
		logic              exp_oe;
		logic [15:0]       exp_dout;
		logic              rd_pend;
		logic [2:0]        cause;
		logic              irq_pend;
		logic [6:0]        irq_oe;
		logic              irq_d;
		logic              edr_d;
		logic              inhibit_n;
		logic              acc_n;
		logic              rdy_n;
		logic              fail_n;
		logic              sysf_n;
		logic              trig_in_n;
		logic [7:0]        trig_oe;
		logic [1:0]        div;
		logic              uclk;
	} vxu_main_t;

	localparam vxu_main_t RST_S = '{
		state:     ST_IDLE,
		exp_stb_n: 1'b1,
		exp_wr_n:  1'b1,
		irq_d:     1'b1,
		edr_d:     1'b1,
		acc_n:     1'b1,
		rdy_n:     1'b1,
		fail_n:    1'b1,
		sysf_n:    1'b1,
		trig_in_n: 1'b1,
		inhibit_n: 1'b1,
		ctrl:      CTRL_RST,
		default:   '0
	};

	vxu_main_t         r;
	vxu_main_t         n;
	logic [SYNC_W-1:0] sy;
	logic [15:0]       exp_s;
	logic [47:0]       io_s;
	logic [7:0]        ttl_s;
	logic              hold_s;
	logic              edr_s;
	logic              irq_s;
	logic [2:0]        code_s;
	logic              jump_s;
	logic              src_s;
	logic              utrig_s;
	logic              sysf_s;
	logic              bclk_s;
	logic              brst;
	logic              rs;
	logic              ostb_start;
	logic              clr_start;
	logic [5:0]        idx;
	logic              access;
	logic [1:0]        tsel;
	logic [2:0]        isel;

	// Expansion range, even word indices only
	function automatic logic is_exp(input logic [5:0] i);
		return (i >= IDX_EXP_LO) && (i <= IDX_EXP_HI) && !i[0];
	endfunction : is_exp

	function automatic logic is_mapped(input logic [5:0] i);
		return is_exp(i) || (i == IDX_CTRL) || (i == IDX_STAT) ||
			(i == IDX_IO0) || (i == IDX_IO1) || (i == IDX_IO2);
	endfunction : is_mapped

	// Bank number of a static IO index
	function automatic logic [1:0] io_bank(input logic [5:0] i);
		if (i == IDX_IO0) begin
			return 2'h0;
		end else if (i == IDX_IO1) begin
			return 2'h1;
		end else begin
			return 2'h2;
		end
	endfunction : io_bank

	vxu_sync #(
		.W    (SYNC_W),
		.INIT ({SYNC_W{1'b1}})
	) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.d       ({exp_data_in, static_io_lines_in, vxi_ttltrg_in,
			transfer_hold_n, external_data_ready_n, user_irq_req_n,
			int_code_bit2_or_board_reset_n, int_code_bit1,
			int_code_bit0, reset_jumper_fitted, clk_source_backplane,
			user_trigger_out_n, vxi_sysfail_n, backplane_clk10}),
		.q       (sy)
	);

	assign {exp_s, io_s, ttl_s, hold_s, edr_s, irq_s, code_s, jump_s,
		src_s, utrig_s, sysf_s, bclk_s} = sy;

	// Jumper fitted: third cause input resets the board logic [R8]
	assign brst = jump_s && !code_s[2];
	assign rs   = reset || brst;

	assign idx    = paddr[7:2];
	assign access = psel && penable && !r.pready;
	assign tsel   = r.ctrl[CTRL_TRIG_LSB +: 2];
	assign isel   = r.ctrl[CTRL_IRQ_LSB +: 3];

	always_comb begin
		logic       irq_fall;
		logic       edr_fall;
		logic       stat_rd;
		logic       inh_clr;
		logic [1:0] bk;
		irq_fall   = r.irq_d && !irq_s;
		edr_fall   = r.edr_d && !edr_s;
		stat_rd    = 1'b0;
		inh_clr    = 1'b0;
		bk         = io_bank(idx);
		ostb_start = 1'b0;
		clr_start  = 1'b0;
		n          = r;
		n.pready   = 1'b0;
		n.pslverr  = 1'b0;

		case (r.state)
			ST_IDLE: begin
				if (access && is_exp(idx)) begin
					// Word index onto four address lines [R1] [R2]
					n.exp_addr  = idx[4:1];
					n.exp_stb_n = 1'b0; // [R3]
					n.exp_wr_n  = !pwrite; // [R4]
					n.exp_oe    = pwrite; // [R1]
					n.exp_dout  = pwdata[15:0];
					n.rd_pend   = !pwrite;
					n.cnt       = EXP_STB_CYC;
					n.state     = ST_STB;
				end else if (access) begin
					n.pready = 1'b1;
					n.prdata = 32'h0000_0000;
					if (!is_mapped(idx)) begin
						n.pslverr = 1'b1;
					end else if (idx == IDX_CTRL) begin
						if (pwrite) begin
							n.ctrl    = pwdata[CTRL_W-1:0];
							clr_start = pwdata[CTRL_CLEAR]; // [R9]
							inh_clr   = pwdata[CTRL_INH_CLR];
						end else begin
							n.prdata[CTRL_W-1:0] = r.ctrl;
						end
					end else if (idx == IDX_STAT) begin
						if (!pwrite) begin
							stat_rd = 1'b1;
							n.prdata[STAT_CAUSE_LSB +: 3] = r.cause;
							n.prdata[STAT_IRQ_PEND] = r.irq_pend;
							n.prdata[STAT_INHIBIT]  = !r.inhibit_n;
							n.prdata[STAT_JUMPER]   = jump_s;
							n.prdata[STAT_SYSFAIL]  = !sysf_s;
						end
					end else begin
						// Static IO bank, direction per bank [R10]
						if (pwrite) begin
							n.io_out[bk*16 +: 16] = pwdata[15:0];
							ostb_start = r.ctrl[CTRL_DIR_LSB + bk]; // [R11]
						end else if (r.ctrl[CTRL_DIR_LSB + bk]) begin
							n.prdata[15:0] = r.io_out[bk*16 +: 16];
						end else begin
							n.prdata[15:0] = io_s[bk*16 +: 16];
						end
					end
				end
			end
			ST_STB: begin
				n.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h1) begin
					n.state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Hold low before strobe end stalls the answer [R5]
				if (hold_s) begin
					n.pready    = 1'b1;
					n.prdata    = r.rd_pend ? {16'h0000, exp_s} : 32'h0;
					n.exp_stb_n = 1'b1;
					n.exp_wr_n  = 1'b1;
					n.exp_oe    = 1'b0;
					n.rd_pend   = 1'b0;
					n.state     = ST_IDLE;
				end
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase

		// Interrupter: latch cause on request pulse [R7] [R6] [R20]
		n.irq_d = irq_s;
		if (irq_fall) begin
			n.cause    = {jump_s ? 1'b0 : code_s[2], code_s[1:0]}; // [R8]
			n.irq_pend = 1'b1;
		end else if (stat_rd) begin
			n.irq_pend = 1'b0;
		end
		n.irq_oe = 7'h00;
		if (n.irq_pend && isel != 3'h0) begin
			n.irq_oe[isel - 3'h1] = 1'b1; // [R7]
		end

		// Data-ready sets the inhibit flip-flop [R12]
		n.edr_d = edr_s;
		if (edr_fall) begin
			n.inhibit_n = 1'b0;
		end else if (inh_clr) begin
			n.inhibit_n = 1'b1;
		end

		// Trigger pair routing [R14] [R15]
		n.trig_in_n = ttl_s[{tsel, 1'b0}];
		n.trig_oe   = 8'h00;
		n.trig_oe[{tsel, 1'b1}] = !utrig_s;

		// User clock: backplane copy or local divide by four [R16]
		n.div  = r.div + 2'h1;
		n.uclk = src_s ? bclk_s : r.div[1];

		// Indicators [R17] [R18] [R19]
		n.acc_n  = !(psel && is_mapped(idx));
		n.rdy_n  = !r.ctrl[CTRL_ST_DONE];
		n.fail_n = !r.ctrl[CTRL_ST_FAIL];
		n.sysf_n = sysf_s;
	end

	always_ff @(posedge clk_sys) begin
		if (rs) begin
			r <= RST_S;
		end else begin
			r <= n;
		end
	end

	vxu_pulse #(
		.DLY (OUT_SETTLE_CYC),
		.WID (OUT_STB_CYC)
	) u_ostb (
		.clk_sys (clk_sys),
		.reset   (rs),
		.start   (ostb_start),
		.pulse_n (output_data_strobe_n)
	);

	vxu_pulse #(
		.DLY (1),
		.WID (CLEAR_CYC)
	) u_clear (
		.clk_sys (clk_sys),
		.reset   (rs),
		.start   (clr_start),
		.pulse_n (user_clear_n)
	);

	assign prdata      = r.prdata;
	assign pready      = r.pready;
	assign pslverr     = r.pslverr;
	assign exp_data_out          = r.exp_dout;
	assign exp_data_oe           = r.exp_oe;
	assign exp_addr              = r.exp_addr;
	assign exp_transfer_strobe_n = r.exp_stb_n;
	assign exp_write_n           = r.exp_wr_n;
	assign static_io_lines_out   = r.io_out;
	assign static_io_lines_oe    = {{16{r.ctrl[CTRL_DIR_LSB + 2]}},
		{16{r.ctrl[CTRL_DIR_LSB + 1]}}, {16{r.ctrl[CTRL_DIR_LSB]}}};
	assign input_inhibit_n       = r.inhibit_n;
	assign vxi_irq_out           = 7'h00;
	assign vxi_irq_oe            = r.irq_oe;
	assign vxi_ttltrg_out        = 8'h00;
	assign vxi_ttltrg_oe         = r.trig_oe;
	assign user_trigger_in_n     = r.trig_in_n;
	assign user_clk10            = r.uclk;
	assign access_indicator_n    = r.acc_n;
	assign ready_indicator_n     = r.rdy_n;
	assign selftest_failed_indicator_n   = r.fail_n;
	assign backplane_failure_indicator_n = r.sysf_n;

endmodule : vxu_card_if

`default_nettype wire

//--- logic/vxu_pkg.sv
// Package: constants, register map and types of the card user interface.
// Assumes a 40 MHz system clock and an APB slave reached at byte 4*index.
`default_nettype none

package vxu_pkg;

	localparam int CLK_MHZ = 40;

	// Least time in ns to whole cycles, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	// Timing
	localparam int       EXP_STB_NS    = 200;
	localparam logic [3:0] EXP_STB_CYC = 4'(ns_to_cyc(EXP_STB_NS));
	localparam int       OUT_SETTLE_NS = 50;
	localparam int       OUT_SETTLE_CYC = ns_to_cyc(OUT_SETTLE_NS);
	localparam int       OUT_STB_NS    = 100;
	localparam int       OUT_STB_CYC   = ns_to_cyc(OUT_STB_NS);
	localparam int       CLEAR_NS      = 1000;
	localparam int       CLEAR_CYC     = ns_to_cyc(CLEAR_NS);

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL   = 6'h1A;
	localparam logic [5:0] IDX_STAT   = 6'h1C;
	localparam logic [5:0] IDX_EXP_LO = 6'h20;
	localparam logic [5:0] IDX_EXP_HI = 6'h38;
	localparam logic [5:0] IDX_IO0    = 6'h3A;
	localparam logic [5:0] IDX_IO1    = 6'h3C;
	localparam logic [5:0] IDX_IO2    = 6'h3E;

	// Control fields
	localparam int CTRL_DIR_LSB  = 0;
	localparam int CTRL_TRIG_LSB = 3;
	localparam int CTRL_IRQ_LSB  = 5;
	localparam int CTRL_ST_DONE  = 8;
	localparam int CTRL_ST_FAIL  = 9;
	localparam int CTRL_CLEAR    = 10;
	localparam int CTRL_INH_CLR  = 11;
	localparam int CTRL_W        = 10;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

	// Status fields
	localparam int STAT_CAUSE_LSB = 0;
	localparam int STAT_IRQ_PEND  = 3;
	localparam int STAT_INHIBIT   = 4;
	localparam int STAT_JUMPER    = 5;
	localparam int STAT_SYSFAIL   = 6;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_STB  = 3'h2,
		ST_HOLD = 3'h4
	} vxu_state_t;

endpackage : vxu_pkg

`default_nettype wire

//--- logic/vxu_pulse.sv
// Delayed active-low pulse generator; restart reloads the delay.
// Assumes start is a one-cycle pulse from clk_sys logic.
`default_nettype none

module vxu_pulse #(
	parameter int DLY = 1,
	parameter int WID = 1
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic start,
	output logic      pulse_n
);

	localparam logic [7:0] TOTAL = 8'(DLY + WID);
	localparam logic [7:0] WID_C = 8'(WID);

	typedef struct packed {
		logic [7:0] cnt;
		logic       out_n;
	} vxu_pulse_t;

	vxu_pulse_t r;
	vxu_pulse_t n;

	always_comb begin
		n = r;
		if (start) begin
			n.cnt = TOTAL;
		end else if (r.cnt != 8'h00) begin
			n.cnt = r.cnt - 8'h01;
		end
		n.out_n = !((n.cnt != 8'h00) && (n.cnt <= WID_C));
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r <= '{8'h00, 1'b1};
		end else begin
			r <= n;
		end
	end

	assign pulse_n = r.out_n;

endmodule : vxu_pulse

`default_nettype wire

//--- logic/vxu_sync.sv
// Three-stage input synchroniser with agreement filter, any width.
// Assumes inputs come from pins outside the clk_sys domain.
`default_nettype none

module vxu_sync #(
	parameter int               W    = 1,
	parameter logic [W-1:0]     INIT = '1
) (
	input  wire logic           clk_sys,
	input  wire logic           reset,
	input  wire logic [W-1:0]   d,
	output logic      [W-1:0]   q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} vxu_sync_t;

	vxu_sync_t r;
	vxu_sync_t n;

	always_comb begin
		n = r;
		n.s1 = d;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// Take a bit once second and third stage agree
		for (int i = 0; i < W; i++) begin
			if (r.s2[i] == r.s3[i]) begin
				n.val[i] = r.s2[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r <= '{INIT, INIT, INIT, INIT};
		end else begin
			r <= n;
		end
	end

	assign q = r.val;

endmodule : vxu_sync

`default_nettype wire

//--- testbench/test_vxu_card_if.sv
// Testbench: APB traffic, user board model and pin stimulus.
// Assumes vxu_pkg, the design and the partner are compiled first.
`default_nettype none

module test_vxu_card_if
	import vxu_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, vxi_ttltrg_in = 0, vxi_ttltrg_oe;
	logic [31:0] pwdata = 0, prdata;
	logic [2:0]  code = 0;
	logic        dat_ready_n = 1, irq_n = 1, jmp = 0, trg_n = 1, sysf_n = 1;
	logic        clk_src = 0;
	logic [2:0]  bp_div = 0;
	logic [47:0] ext_io = 0, static_io_lines_out, static_io_lines_oe;
	logic [15:0] exp_data_in, exp_data_out;
	logic [6:0]  vxi_irq_oe;
	logic [3:0]  exp_addr;
	logic [4:0]  hold_len = 0;
	logic        pready, pslverr, exp_transfer_strobe_n, exp_write_n;
	logic        transfer_hold_n, output_data_strobe_n, input_inhibit_n;
	logic        user_trigger_in_n, user_clk10, user_clear_n;
	logic        access_indicator_n, ready_indicator_n;
	logic        selftest_failed_indicator_n, backplane_failure_indicator_n;
	int          n_fail = 0, num_checks = 0, seed = 58;
	typedef struct packed { logic [32:0] v; logic [32:0] m; } vxu_note_t;
	vxu_note_t   notes [$];
	wire  [47:0] static_io_lines_in = (static_io_lines_oe & static_io_lines_out)
		| (~static_io_lines_oe & ext_io);

	always #12.5 clk_sys = ~clk_sys;

	// Free-running backplane clock at an eighth of clk_sys
	always @(posedge clk_sys) bp_div <= bp_div + 3'h1;

	vxu_card_if vxu_card_if_i (
		.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .exp_data_in, .exp_data_out, .exp_data_oe(),
		.exp_addr, .exp_transfer_strobe_n, .exp_write_n, .transfer_hold_n,
		.static_io_lines_in, .static_io_lines_out, .static_io_lines_oe,
		.output_data_strobe_n, .external_data_ready_n(dat_ready_n),
		.input_inhibit_n, .user_irq_req_n(irq_n), .int_code_bit0(code[0]),
		.int_code_bit1(code[1]), .int_code_bit2_or_board_reset_n(code[2]),
		.reset_jumper_fitted(jmp), .vxi_irq_out(), .vxi_irq_oe,
		.vxi_ttltrg_in, .vxi_ttltrg_out(), .vxi_ttltrg_oe, .user_trigger_in_n,
		.user_trigger_out_n(trg_n), .backplane_clk10(bp_div[2]),
		.clk_source_backplane(clk_src), .user_clk10, .user_clear_n,
		.access_indicator_n, .ready_indicator_n, .selftest_failed_indicator_n,
		.vxi_sysfail_n(sysf_n), .backplane_failure_indicator_n
	);

	vxu_user_board vxu_user_board_i (
		.clk_sys, .reset, .exp_addr, .exp_data_out, .exp_transfer_strobe_n,
		.exp_write_n, .hold_len, .exp_data_in, .transfer_hold_n
	);

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] v, input logic [32:0] m);
		int k;
		notes.push_back('{v, m});
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 200);
		penable <= 1'b0;
		psel    <= 1'b0;
		if (k >= 200) begin
			n_fail++;
			tally_and_finish();
		end
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, 33'h100000000);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] v);
		apb(1'b0, a, 32'h0, v, 33'h1FFFFFFFF);
	endtask : rd

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt

	// Answer checker: oldest note against each answer
	always @(posedge clk_sys) begin
		vxu_note_t n;
		if (pready === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			chk({pslverr, prdata} & n.m, n.v & n.m);
		end
	end

	initial begin
		logic [15:0] d [13];
		logic [31:0] r;
		int          k;
		bit          p;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		wr(8'h68, 32'h373);
		rd(8'h68, 33'h373);
		chk({ready_indicator_n, selftest_failed_indicator_n}, 33'h0);
		for (int i = 0; i < 13; i++) begin
			d[i] = 16'($random(seed));
			hold_len <= (i % 2) ? 5'h10 : 5'h00;
			wr(8'h80 + 8'(i * 8), {16'h0, d[i]});
		end
		for (int i = 12; i >= 0; i--) begin
			hold_len <= (i % 3) ? 5'h00 : 5'h0C;
			rd(8'h80 + 8'(i * 8), {17'h0, d[i]});
		end
		rd(8'h84, {1'b1, 32'h0});
		rd(8'h00, {1'b1, 32'h0});
		ext_io <= {16'($random(seed)), 32'h0};
		for (int b = 0; b < 3; b++) begin
			r = $random(seed);
			wr(8'hE8 + 8'(b * 8), r);
			k = 0;
			while (output_data_strobe_n !== 1'b0 && k < 12) begin
				@(posedge clk_sys);
				k++;
			end
			chk(k < 12, b < 2);
			if (b < 2)
				chk(33'(static_io_lines_out[b*16 +: 16]), 33'(r[15:0]));
			rd(8'hE8 + 8'(b * 8), {17'h0, b < 2 ? r[15:0] : ext_io[47:32]});
		end
		chk(33'(static_io_lines_oe[47:16]), 33'h0000FFFF);
		dat_ready_n <= 1'b0;
		wt(4);
		dat_ready_n <= 1'b1;
		wt(8);
		chk(input_inhibit_n, 1'b0);
		rd(8'h70, 33'h10);
		wr(8'h68, 32'h963);
		wt(4);
		chk({input_inhibit_n, ready_indicator_n,
			selftest_failed_indicator_n}, 33'h5);
		for (int i = 0; i < 8; i++) begin
			code <= 3'(i);
			wt(6);
			irq_n <= 1'b0;
			wt(4);
			irq_n <= 1'b1;
			wt(8);
			chk(vxi_irq_oe, 7'h04);
			rd(8'h70, 33'(i + 8));
			wt(2);
			chk(vxi_irq_oe, 7'h00);
		end
		jmp  <= 1'b1;
		code <= 3'h7;
		wt(6);
		irq_n <= 1'b0;
		wt(4);
		irq_n <= 1'b1;
		wt(8);
		rd(8'h70, 33'h2B);
		code <= 3'h3;
		wt(8);
		code <= 3'h7;
		wt(8);
		rd(8'h68, 33'h0);
		for (int s = 0; s < 4; s++) begin
			wr(8'h68, 32'h160 | 32'(s << 3));
			vxi_ttltrg_in <= 8'($random(seed));
			trg_n         <= 1'b0;
			wt(8);
			chk(user_trigger_in_n, vxi_ttltrg_in[2 * s]);
			chk(vxi_ttltrg_oe, 8'h02 << (2 * s));
			trg_n <= 1'b1;
			wt(10);
		end
		sysf_n <= 1'b0;
		wt(8);
		chk(backplane_failure_indicator_n, 1'b0);
		rd(8'h70, 33'h60);
		wr(8'h68, 32'h400);
		wt(10);
		chk(user_clear_n, 1'b0);
		wt(40);
		chk(user_clear_n, 1'b1);
		for (int m = 0; m < 2; m++) begin
			clk_src <= (m == 1);
			wt(8);
			p = user_clk10;
			k = 0;
			for (int i = 0; i < 40; i++) begin
				@(posedge clk_sys);
				if (user_clk10 === 1'b1 && !p)
					k++;
				p = user_clk10;
			end
			chk(33'(k), (m == 1) ? 33'h5 : 33'hA);
		end
		tally_and_finish();
	end
endmodule : test_vxu_card_if

bind vxu_card_if vxu_card_if_asserts vxu_card_if_asserts_i (
	.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pready, .exp_addr,
	.exp_transfer_strobe_n, .exp_write_n, .exp_data_oe, .transfer_hold_n,
	.output_data_strobe_n, .external_data_ready_n, .input_inhibit_n,
	.user_clear_n, .user_trigger_out_n, .vxi_ttltrg_oe, .access_indicator_n
);

`default_nettype wire

//--- testbench/vxu_card_if_asserts.sv
// Checker: timing relations at the card interface ports.
// Assumes a bind into vxu_card_if; one clock, synchronous reset.
`default_nettype none

module vxu_card_if_asserts (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic [3:0] exp_addr,
	input wire logic       exp_transfer_strobe_n,
	input wire logic       exp_write_n,
	input wire logic       exp_data_oe,
	input wire logic       transfer_hold_n,
	input wire logic       output_data_strobe_n,
	input wire logic       external_data_ready_n,
	input wire logic       input_inhibit_n,
	input wire logic       user_clear_n,
	input wire logic       user_trigger_out_n,
	input wire logic [7:0] vxi_ttltrg_oe,
	input wire logic       access_indicator_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	logic [5:0] clr_cnt;
	logic [3:0] up;

	// Clear pulse length and settle time after reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clr_cnt <= 6'h00;
			up      <= 4'h0;
		end else begin
			clr_cnt <= user_clear_n ? 6'h00 : clr_cnt + 6'h01;
			up      <= (up == 4'hF) ? up : up + 4'h1;
		end
	end

	a_stb_cause: assert property (
		$fell(exp_transfer_strobe_n) |-> $past(psel && penable &&
		paddr[7:2] >= 6'h20 && paddr[7:2] <= 6'h38))
		else $error("strobe without expansion address");
	a_stb_addr: assert property (
		$fell(exp_transfer_strobe_n) |-> exp_addr == $past(paddr[6:3]))
		else $error("wrong expansion word address");
	a_write_dir: assert property (
		!exp_transfer_strobe_n |-> exp_write_n == !pwrite)
		else $error("write line disagrees with direction");
	a_hold_stall: assert property (
		(!transfer_hold_n && !exp_transfer_strobe_n)[*6] |=> !pready)
		else $error("answer given while held");
	a_hold_free: assert property (
		$rose(transfer_hold_n) && !exp_transfer_strobe_n
		|-> ##[1:10] pready)
		else $error("no answer after hold release");
	a_out_stb: assert property (
		$fell(output_data_strobe_n)
		|-> !output_data_strobe_n[*4] ##1 output_data_strobe_n)
		else $error("output strobe width wrong");
	a_clear_len: assert property (
		$rose(user_clear_n) |-> clr_cnt == 6'h28)
		else $error("clear pulse length wrong");
	a_inh_set: assert property (
		up == 4'hF && $fell(external_data_ready_n)
		|-> ##[1:8] !input_inhibit_n)
		else $error("inhibit not set");
	a_trig_idle: assert property (
		(up == 4'hF && user_trigger_out_n)[*8] |-> vxi_ttltrg_oe == 8'h00)
		else $error("trigger driven while idle");
	a_access_led: assert property (
		psel && paddr[7:2] inside {6'h1A, 6'h1C, 6'h3A, 6'h3C, 6'h3E}
		|=> !access_indicator_n)
		else $error("access indicator off");
	a_oe_write: assert property (
		exp_data_oe == (!exp_transfer_strobe_n && !exp_write_n))
		else $error("data drive outside expansion write");
endmodule : vxu_card_if_asserts

`default_nettype wire

//--- testbench/vxu_user_board.sv
// Partner: user board logic answering on the expansion bus.
// Assumes a store of 16 words and a hold length set by the bench.
`default_nettype none

module vxu_user_board (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [3:0]  exp_addr,
	input  wire logic [15:0] exp_data_out,
	input  wire logic        exp_transfer_strobe_n,
	input  wire logic        exp_write_n,
	input  wire logic [4:0]  hold_len,
	output logic      [15:0] exp_data_in,
	output logic             transfer_hold_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [16];
	logic [15:0] last;
	logic        stb_q;
	logic [4:0]  cnt;
	wire         drive = !exp_transfer_strobe_n && exp_write_n;

	// Released bus shows a changing pattern
	assign exp_data_in = drive ? mem[exp_addr] : ~last;

	always_ff @(posedge clk_sys) begin
		last  <= exp_data_in;
		stb_q <= exp_transfer_strobe_n;
		if (reset) begin
			last            <= 16'h0000;
			transfer_hold_n <= 1'b1;
			cnt             <= 5'h00;
		end else if (stb_q && !exp_transfer_strobe_n) begin
			transfer_hold_n <= (hold_len == 5'h00);
			cnt             <= 5'h01;
		end else begin
			cnt <= cnt + 5'h01;
			if (cnt == hold_len)
				transfer_hold_n <= 1'b1;
		end
		if (!exp_transfer_strobe_n && !exp_write_n)
			mem[exp_addr] <= exp_data_out;
	end
endmodule : vxu_user_board

`default_nettype wire
